// File: src/hmc_consts.svh
// Constants for the hub memory cycle target.
// Assumes inclusion by bare name from design files under src/.
// ----------------------------------------------------------------------
// What this block does
// ----------------------------------------------------------------------
`ifndef HMC_CONSTS_SVH
`define HMC_CONSTS_SVH

`define HMC_START_READ   4'hD
`define HMC_START_WRITE  4'hE
`define HMC_SIZE_BYTE    4'h0
`define HMC_SYNC_WAIT    4'h5
`define HMC_SYNC_READY   4'h0
`define HMC_TAR_DRIVE    4'hF
`define HMC_ADDR_NIBBLES 3'h7
`define HMC_ADDR_ARRAY_BIT 22
`define HMC_WAIT_DEFAULT 4'h2

`endif

// File: src/hmc_pkg.sv
// Types for the hub memory cycle target.
// Assumes hmc_consts.svh is included alongside.
package hmc_pkg;
	typedef enum logic [3:0]
	{
		HMC_IDLE    = 4'b0000,
		HMC_SELECT  = 4'b0001,
		HMC_ADDR    = 4'b0010,
		HMC_SIZE    = 4'b0011,
		HMC_WDATA   = 4'b0100,
		HMC_TAR_IN  = 4'b0101,
		HMC_SYNC    = 4'b0110,
		HMC_RDATA   = 4'b0111,
		HMC_TAR_OUT = 4'b1000,
		HMC_FLOAT   = 4'b1001,
		HMC_STANDBY = 4'b1010
	} hmc_state_t;

	typedef enum logic [1:0]
	{
		HMC_MODE_ARRAY  = 2'b00,
		HMC_MODE_STATUS = 2'b01,
		HMC_MODE_IDENT  = 2'b10
	} hmc_mode_t;
endpackage : hmc_pkg

// File: src/hmc_target.sv
// Hub memory cycle target: nibble-bus decode, sync and data return.
// Assumes inputs synchronous to mclk; the surrounding core supplies
// read data and takes write bytes over the user ports.
`timescale 1ns/1ps
`include "hmc_consts.svh"

module hmc_target
#(
	parameter logic [3:0] WAIT_CLOCKS = `HMC_WAIT_DEFAULT
)
(
	input  wire logic        mclk,            // Bus clock
	input  wire logic        srst,            // Sync reset, high
	input  wire logic        frame_strobe_n,  // Frame strobe, low
	input  wire logic [3:0]  nibble_bus_in,   // Bus level seen
	output logic      [3:0]  nibble_bus_out,  // Bus level driven
	output logic             nibble_bus_oe_n, // Low while driving
	input  wire logic [3:0]  strap_identity,  // Strapped select
	input  wire logic        core_busy,       // Internal op running
	input  wire logic [7:0]  array_rdata,     // Array byte
	input  wire logic [7:0]  lock_rdata,      // Sector lock byte
	input  wire logic [7:0]  gpi_rdata,       // General input byte
	input  wire logic [7:0]  status_rdata,    // Status byte
	input  wire logic [7:0]  ident_rdata,     // Identity byte
	input  wire logic [1:0]  read_mode,       // hmc_pkg::hmc_mode_t
	output logic             rd_req,          // Read fetch pulse
	output logic             wr_strobe,       // Write byte pulse
	output logic             wr_to_array,     // Write target array
	output logic      [21:0] loc_addr,        // Decoded location
	output logic      [7:0]  wr_data,         // Written byte
	output logic             other_cycle,     // Hand to other decoder
	output logic             standby          // Low-power standby
);

	hmc_pkg::hmc_state_t state_r;
	hmc_pkg::hmc_state_t state_nxt;
	logic                is_write_r;
	logic [2:0]          cnt_r;
	logic [3:0]          wait_r;
	logic [27:0]         addr_r;
	logic [7:0]          rbyte_r;
	logic [3:0]          out_r;
	logic                oe_n_r;
	logic                frame_d_r;
	logic                rd_req_r;
	logic                wr_strobe_r;
	logic                other_r;
	logic                standby_r;
	logic [7:0]          wdata_r;
	logic                start_ok_r;
	hmc_pkg::hmc_mode_t  mode_r;

	function automatic logic [7:0] read_pick
	(
		input logic [27:0] a,
		input logic [1:0]  m,
		input logic [7:0]  arr,
		input logic [7:0]  lck,
		input logic [7:0]  gpi,
		input logic [7:0]  sts,
		input logic [7:0]  idn
	);
		logic [7:0] r;
		r = arr;
		if (!a[`HMC_ADDR_ARRAY_BIT])
		begin
			r = a[0] ? gpi : lck;
		end
		else if (m == hmc_pkg::HMC_MODE_STATUS)
		begin
			r = sts;
		end
		else if (m == hmc_pkg::HMC_MODE_IDENT)
		begin
			r = idn;
		end
		return r;
	endfunction : read_pick

	// ------------------------------------------------------------------
	// Cycle decoder
	// ------------------------------------------------------------------
	// Start is taken only once the strobe goes high again, so the
	// last low clock's nibble wins; the next clock is select.
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			hmc_pkg::HMC_IDLE,
			hmc_pkg::HMC_STANDBY:
				state_nxt = state_r;
			hmc_pkg::HMC_SELECT:
				state_nxt = (start_ok_r &&
					nibble_bus_in == strap_identity) ?
					hmc_pkg::HMC_ADDR : hmc_pkg::HMC_STANDBY;
			hmc_pkg::HMC_ADDR:
				if (cnt_r == (`HMC_ADDR_NIBBLES - 3'h1))
				begin
					state_nxt = hmc_pkg::HMC_SIZE;
				end
			hmc_pkg::HMC_SIZE:
				if (nibble_bus_in != `HMC_SIZE_BYTE)
				begin
					state_nxt = hmc_pkg::HMC_STANDBY;
				end
				else if (is_write_r)
				begin
					state_nxt = hmc_pkg::HMC_WDATA;
				end
				else
				begin
					state_nxt = hmc_pkg::HMC_TAR_IN;
				end
			hmc_pkg::HMC_WDATA:
				if (cnt_r == 3'h1)
				begin
					state_nxt = hmc_pkg::HMC_TAR_IN;
				end
			hmc_pkg::HMC_TAR_IN:
				if (cnt_r == 3'h1)
				begin
					state_nxt = hmc_pkg::HMC_SYNC;
				end
			hmc_pkg::HMC_SYNC:
				if (is_write_r || wait_r == 4'h0)
				begin
					state_nxt = is_write_r ? hmc_pkg::HMC_TAR_OUT
						: hmc_pkg::HMC_RDATA;
				end
			hmc_pkg::HMC_RDATA:
				if (cnt_r == 3'h1)
				begin
					state_nxt = hmc_pkg::HMC_TAR_OUT;
				end
			hmc_pkg::HMC_TAR_OUT:
				state_nxt = hmc_pkg::HMC_FLOAT;
			hmc_pkg::HMC_FLOAT:
				state_nxt = hmc_pkg::HMC_IDLE;
			default:
				state_nxt = hmc_pkg::HMC_IDLE;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		frame_d_r <= srst ? 1'b0 : ~frame_strobe_n;
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			state_r    <= hmc_pkg::HMC_IDLE;
			is_write_r <= 1'b0;
			other_r    <= 1'b0;
		end
		else if (!frame_strobe_n)
		begin
			state_r <= hmc_pkg::HMC_SELECT;
			other_r <= 1'b0;
			if (nibble_bus_in == `HMC_START_READ)
			begin
				is_write_r <= 1'b0;
			end
			else if (nibble_bus_in == `HMC_START_WRITE)
			begin
				is_write_r <= 1'b1;
			end
		end
		else if (frame_d_r && !start_ok_r)
		begin
			// Strobe just rose on a start code that is not ours.
			state_r <= hmc_pkg::HMC_STANDBY;
			other_r <= 1'b1;
		end
		else
		begin
			state_r <= state_nxt;
			other_r <= 1'b0;
		end
	end

	// Mode follows the core; reset forces array reads only while it is held.
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			mode_r <= hmc_pkg::HMC_MODE_ARRAY;
		end
		else
		begin
			mode_r <= hmc_pkg::hmc_mode_t'(read_mode);
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			start_ok_r <= 1'b0;
		end
		else if (!frame_strobe_n)
		begin
			start_ok_r <= (nibble_bus_in == `HMC_START_READ) ||
				(nibble_bus_in == `HMC_START_WRITE);
		end
	end

	// ------------------------------------------------------------------
	// Counters and capture
	// ------------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (srst || state_nxt != state_r || !frame_strobe_n)
		begin
			cnt_r <= 3'h0;
		end
		else
		begin
			cnt_r <= cnt_r + 3'h1;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			addr_r <= 28'h0000000;
		end
		else if (state_r == hmc_pkg::HMC_ADDR && frame_strobe_n)
		begin
			addr_r <= {addr_r[23:0], nibble_bus_in};
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			wdata_r     <= 8'h00;
			wr_strobe_r <= 1'b0;
		end
		else
		begin
			wr_strobe_r <= 1'b0;
			if (state_r == hmc_pkg::HMC_WDATA && frame_strobe_n)
			begin
				if (cnt_r == 3'h0)
				begin
					wdata_r[3:0] <= nibble_bus_in;
				end
				else
				begin
					wdata_r[7:4] <= nibble_bus_in;
					wr_strobe_r  <= 1'b1;
				end
			end
		end
	end

	// Access time is modelled as a fixed wait count per read.
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			wait_r   <= 4'h0;
			rd_req_r <= 1'b0;
			rbyte_r  <= 8'h00;
		end
		else
		begin
			rd_req_r <= 1'b0;
			if (state_r == hmc_pkg::HMC_TAR_IN && cnt_r == 3'h1
				&& frame_strobe_n)
			begin
				wait_r   <= WAIT_CLOCKS;
				rd_req_r <= ~is_write_r;
			end
			else if (state_r == hmc_pkg::HMC_SYNC && wait_r != 4'h0)
			begin
				wait_r <= wait_r - 4'h1;
			end
			// Fetch from the first turn-around clock so a zero wait count
			// still has the byte ready.
			if (state_r == hmc_pkg::HMC_TAR_IN
				|| state_r == hmc_pkg::HMC_SYNC)
			begin
				rbyte_r <= read_pick(addr_r, mode_r, array_rdata,
					lock_rdata, gpi_rdata, status_rdata, ident_rdata);
			end
		end
	end

	// ------------------------------------------------------------------
	// Bus drive
	// ------------------------------------------------------------------
	// Outputs are registered from the next state so the drive lands
	// in the clock the field belongs to.
	always_ff @(posedge mclk)
	begin
		if (srst || !frame_strobe_n)
		begin
			oe_n_r <= 1'b1;
			out_r  <= `HMC_TAR_DRIVE;
		end
		else
		begin
			oe_n_r <= 1'b0;
			out_r  <= `HMC_TAR_DRIVE;
			case (state_nxt)
				// Read takes the bus in the second turn-around clock.
				hmc_pkg::HMC_TAR_IN:
					oe_n_r <= is_write_r
						|| state_r != hmc_pkg::HMC_TAR_IN;
				hmc_pkg::HMC_SYNC:
					out_r <= (is_write_r || (state_r == hmc_pkg::HMC_SYNC ?
						wait_r == 4'h1 : WAIT_CLOCKS == 4'h0)) ?
						`HMC_SYNC_READY : `HMC_SYNC_WAIT;
				hmc_pkg::HMC_RDATA:
					out_r <= (cnt_r == 3'h0 && state_r ==
						hmc_pkg::HMC_RDATA) ? rbyte_r[7:4]
						: rbyte_r[3:0];
				hmc_pkg::HMC_TAR_OUT:
					out_r <= `HMC_TAR_DRIVE;
				default:
					oe_n_r <= 1'b1;
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		standby_r <= srst ? 1'b0 :
			(state_r == hmc_pkg::HMC_STANDBY && frame_strobe_n
			&& !core_busy);
	end

	assign nibble_bus_out  = out_r;
	assign nibble_bus_oe_n = oe_n_r;
	assign rd_req          = rd_req_r;
	assign wr_strobe       = wr_strobe_r;
	assign wr_to_array     = addr_r[`HMC_ADDR_ARRAY_BIT];
	assign loc_addr        = {addr_r[22], 3'h0, addr_r[17:0]};
	assign wr_data         = wdata_r;
	assign other_cycle     = other_r;
	assign standby         = standby_r;

endmodule : hmc_target

// File: testbench/hmc_host_model.sv
// Bus host model: frames hub memory cycles and records the lines.
// Assumes the bench resolves the shared lines from both enables.
`timescale 1ns/1ps
module hmc_host_model
(
	input  wire logic       mclk,     // Bus clock
	input  wire logic [3:0] bus,      // Resolved lines
	input  wire logic       dev_oe_n, // Device drives, low
	output logic            frame_n,  // Frame strobe, low
	output logic      [3:0] hval,     // Host drive value
	output logic            hen       // Host drives lines
);
	// ---
	// Trace of {dev_oe_n, bus} per clock of a cycle
	// ---
	logic [4:0] trace [1:24];
	initial
	begin
		frame_n = 1'b1;
		hval = 4'hF;
		hen = 1'b0;
	end
	// Clocks before 1 hold the frame low with a junk nibble
	task automatic xfer(input logic [3:0] st, sel, sz,
		input logic [27:0] a, input logic [7:0] wd, input int pre, n);
		logic [3:0] v;
		for (int k = 1 - pre; k <= n; k++)
		begin
			v = 4'hF;
			if (k <= 1)
				v = (k == 1) ? st : 4'h9;
			else if (k == 2)
				v = sel;
			else if (k <= 9)
				v = a[4*(9-k) +: 4];
			else if (k == 10)
				v = sz;
			else if (st == 4'hE && k <= 12)
				v = (k == 11) ? wd[3:0] : wd[7:4];
			frame_n <= (k > 1);
			hval <= v;
			hen <= (k < (st == 4'hE ? 14 : 12));
			@(posedge mclk);
			if (k >= 1)
				trace[k] = {dev_oe_n, bus};
		end
	endtask : xfer
endmodule : hmc_host_model

// File: testbench/hmc_target_monitor.sv
// Protocol checker for the hub memory cycle target.
// Assumes it is bound to hmc_target and sees its ports only.
`timescale 1ns/1ps
module hmc_target_monitor
#(
	parameter logic [3:0] WAIT_CLOCKS = 4'h2
)
(
	input wire logic       mclk,            // Bus clock
	input wire logic       srst,            // Sync reset
	input wire logic       frame_strobe_n,  // Frame strobe
	input wire logic [3:0] nibble_bus_in,   // Lines seen
	input wire logic [3:0] nibble_bus_out,  // Lines driven
	input wire logic       nibble_bus_oe_n, // Drive enable
	input wire logic [3:0] strap_identity,  // Straps
	input wire logic       other_cycle,     // Hand-off
	input wire logic       standby          // Standby
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	// ---
	// Wait sync run length seen so far
	// ---
	logic [3:0] wait_cnt_r;
	always_ff @(posedge mclk)
		if (srst || nibble_bus_oe_n || nibble_bus_out != 4'h5)
			wait_cnt_r <= 4'h0;
		else
			wait_cnt_r <= wait_cnt_r + 4'h1;
	frame_abort_a:
	assert property (!frame_strobe_n |=> nibble_bus_oe_n)
		else $error("lines driven after frame strobe");
	read_start_a:
	assert property (!frame_strobe_n && nibble_bus_in == 4'hD
		##1 frame_strobe_n && nibble_bus_in == strap_identity
		##8 frame_strobe_n && nibble_bus_in == 4'h0
		|-> ##2 !nibble_bus_oe_n && nibble_bus_out == 4'hF)
		else $error("read turn-around not driven");
	wait_count_a:
	assert property (!nibble_bus_oe_n && nibble_bus_out == 4'h0
		&& $past(nibble_bus_out) == 4'h5 |-> wait_cnt_r == WAIT_CLOCKS)
		else $error("wrong wait sync count");
	read_tail_a:
	assert property (!nibble_bus_oe_n && nibble_bus_out == 4'h0
		&& !$past(nibble_bus_oe_n) |=> !nibble_bus_oe_n [*2]
		##1 !nibble_bus_oe_n && nibble_bus_out == 4'hF
		##1 nibble_bus_oe_n)
		else $error("read data tail wrong");
	write_ack_a:
	assert property (!nibble_bus_oe_n && nibble_bus_out == 4'h0
		&& $past(nibble_bus_oe_n) |=> !nibble_bus_oe_n
		&& nibble_bus_out == 4'hF ##1 nibble_bus_oe_n)
		else $error("write ack tail wrong");
	select_miss_a:
	assert property (!frame_strobe_n ##1 frame_strobe_n
		&& nibble_bus_in != strap_identity |-> ##10 nibble_bus_oe_n [*8])
		else $error("unselected device drove lines");
	size_refuse_a:
	assert property (!frame_strobe_n && nibble_bus_in[3:2] == 2'h3
		##1 frame_strobe_n && nibble_bus_in == strap_identity
		##8 frame_strobe_n && nibble_bus_in != 4'h0
		|-> ##1 nibble_bus_oe_n [*8])
		else $error("bad size answered");
	other_cycle_a:
	assert property (!frame_strobe_n && nibble_bus_in != 4'hD
		&& nibble_bus_in != 4'hE ##1 frame_strobe_n |-> ##[0:2] other_cycle)
		else $error("foreign start not handed off");
	reset_float_a:
	assert property (disable iff (1'b0) srst |=> nibble_bus_oe_n && !standby)
		else $error("reset left lines driven");
endmodule : hmc_target_monitor

// File: testbench/tb.sv
// Self-checking bench for the hub memory cycle target.
// Assumes hmc_host_model as host and pull-ups on the nibble lines.
`timescale 1ns/1ps
module tb;
	logic        mclk, srst, core_busy, oe_n, frame_n, hen, wr_arr;
	logic        wr_strobe, wr_to_array, other_cycle, standby, rd_req;
	logic [3:0]  strap, dout, bus, hval;
	logic [1:0]  read_mode;
	logic [7:0]  wr_data, wr_seen;
	logic [21:0] loc_addr;
	int          n_errors, samples_checked, wr_cnt, oth_cnt, rd_cnt;
	always #2 mclk = ~mclk;
	assign bus = !oe_n ? dout : (hen ? hval : 4'hF);
	hmc_target i_hmc_target (.mclk(mclk), .srst(srst),
		.frame_strobe_n(frame_n), .nibble_bus_in(bus),
		.nibble_bus_out(dout), .nibble_bus_oe_n(oe_n),
		.strap_identity(strap), .core_busy(core_busy),
		.array_rdata(8'hA7), .lock_rdata(8'h3C), .gpi_rdata(8'h5E),
		.status_rdata(8'h81), .ident_rdata(8'h6B), .read_mode(read_mode),
		.rd_req(rd_req), .wr_strobe(wr_strobe), .wr_to_array(wr_to_array),
		.loc_addr(loc_addr), .wr_data(wr_data),
		.other_cycle(other_cycle), .standby(standby));
	hmc_host_model i_hmc_host_model (.mclk(mclk), .bus(bus),
		.dev_oe_n(oe_n), .frame_n(frame_n), .hval(hval), .hen(hen));
	always @(posedge mclk)
	begin
		if (wr_strobe === 1'b1)
		begin
			wr_cnt <= wr_cnt + 1;
			wr_seen <= wr_data;
			wr_arr <= wr_to_array;
		end
		if (other_cycle === 1'b1)
			oth_cnt <= oth_cnt + 1;
		if (rd_req === 1'b1)
			rd_cnt <= rd_cnt + 1;
	end
	task automatic chk(input logic [31:0] got, exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_bus(input int k, input logic [4:0] exp);
		chk({27'h0, i_hmc_host_model.trace[k]}, {27'h0, exp});
	endtask : chk_bus
	task automatic no_drive();
		for (int k = 1; k <= 20; k++)
			chk(32'(i_hmc_host_model.trace[k][4]), 32'h1);
	endtask : no_drive
	task automatic rd(input logic [27:0] a, input logic [7:0] d, input int p);
		i_hmc_host_model.xfer(4'hD, strap, 4'h0, a, 8'h00, p, 20);
		chk_bus(11, 5'h1F);
		chk_bus(12, 5'h0F);
		chk_bus(13, 5'h05);
		chk_bus(14, 5'h05);
		chk_bus(15, 5'h00);
		chk_bus(16, {1'b0, d[3:0]});
		chk_bus(17, {1'b0, d[7:4]});
		chk_bus(18, 5'h0F);
		chk_bus(19, 5'h1F);
		chk(32'(loc_addr), 32'({a[22], 3'h0, a[17:0]}));
	endtask : rd
	task automatic t_sources();
		rd(28'hFC72345, 8'hA7, 1);
		rd(28'hFB00001, 8'h5E, 0);
		rd(28'hFB00000, 8'h3C, 0);
		read_mode <= 2'h1;
		rd(28'hFC00000, 8'h81, 0);
		read_mode <= 2'h2;
		rd(28'hFC00000, 8'h6B, 0);
		read_mode <= 2'h0;
		chk(32'(rd_cnt), 32'h5);
	endtask : t_sources
	task automatic t_write();
		i_hmc_host_model.xfer(4'hE, strap, 4'h0, 28'hFC00010, 8'h96, 0, 20);
		chk_bus(14, 5'h1F);
		chk_bus(15, 5'h00);
		chk_bus(16, 5'h0F);
		chk_bus(17, 5'h1F);
		chk(32'(wr_cnt), 32'h1);
		chk(32'(wr_seen), 32'h96);
		chk(32'(wr_arr), 32'h1);
		chk(32'(rd_cnt), 32'h5);
	endtask : t_write
	task automatic t_refuse();
		i_hmc_host_model.xfer(4'hD, ~strap, 4'h0, 28'hFC0, 8'h0, 0, 20);
		no_drive();
		chk(32'(standby), 32'h1);
		core_busy <= 1'b1;
		i_hmc_host_model.xfer(4'h3, strap, 4'h0, 28'hFC0, 8'h0, 0, 20);
		no_drive();
		chk(32'(oth_cnt), 32'h1);
		chk(32'(standby), 32'h0);
		core_busy <= 1'b0;
		repeat (3) @(posedge mclk);
		chk(32'(standby), 32'h1);
		i_hmc_host_model.xfer(4'hD, strap, 4'h1, 28'hFC0, 8'h0, 0, 20);
		no_drive();
		chk(32'(rd_cnt), 32'h5);
	endtask : t_refuse
	// Abort lands mid wait sync; a new start must then decode
	task automatic t_abort();
		i_hmc_host_model.xfer(4'hD, strap, 4'h0, 28'hFC00000, 8'h0, 0, 13);
		rd(28'hFC00000, 8'hA7, 1);
		chk_bus(1, 5'h1D);
		chk(32'(rd_cnt), 32'h7);
	endtask : t_abort
	task automatic finish_test();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test
	initial
	begin
		mclk = 1'b0;
		srst = 1'b1;
		core_busy = 1'b0;
		strap = 4'hA;
		read_mode = 2'h0;
		{n_errors, samples_checked, wr_cnt, oth_cnt, rd_cnt} = '0;
		repeat (5) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		chk(32'(oe_n), 32'h1);
		t_sources();
		t_write();
		t_refuse();
		t_abort();
		finish_test();
	end
	initial
	begin
		#(4 * 2000);
		n_errors++;
		finish_test();
	end
endmodule : tb
bind hmc_target hmc_target_monitor #(.WAIT_CLOCKS(WAIT_CLOCKS)) i_mon (
	.mclk(mclk), .srst(srst), .frame_strobe_n(frame_strobe_n),
	.nibble_bus_in(nibble_bus_in), .nibble_bus_out(nibble_bus_out),
	.nibble_bus_oe_n(nibble_bus_oe_n), .strap_identity(strap_identity),
	.other_cycle(other_cycle), .standby(standby));
